/* pkg/pco_pkg.sv */
// package: constants, carriers and states of the counter overflow interrupt block
package pco_pkg;

  // ************************************************************
  // bus and field widths
  // ************************************************************
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CNT_W    = 32;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned BANK_W   = 32;
  localparam int unsigned IRQ_SRC_W = 2;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  // views: base + 4*x, x = 0..7, address bits [7:5] pick the view
  localparam logic [11:0] ENCLR_BASE = 12'h000;
  localparam logic [11:0] ENSET_BASE = 12'h020;
  localparam logic [11:0] OVCLR_BASE = 12'h040;
  localparam logic [11:0] OVSET_BASE = 12'h060;
  localparam logic [11:0] CTRL_OFS   = 12'h080;
  localparam logic [11:0] STAT_OFS   = 12'h084;
  localparam logic [11:0] MASK_OFS   = 12'h088;

  localparam logic [2:0] VIEW_ENCLR = 3'h0;
  localparam logic [2:0] VIEW_ENSET = 3'h1;
  localparam logic [2:0] VIEW_OVCLR = 3'h2;
  localparam logic [2:0] VIEW_OVSET = 3'h3;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int unsigned CTRL_GEN_BIT = 0;
  localparam int unsigned STAT_OVF_BIT = 0;
  localparam int unsigned STAT_ERR_BIT = 1;
  localparam logic        CTRL_RST     = 1'h0;
  localparam logic [1:0]  STAT_RST     = 2'h0;
  localparam logic [1:0]  MASK_RST     = 2'h0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef enum logic [1:0] {
    APB_IDLE   = 2'b01,
    APB_ACCESS = 2'b10
  } pco_apb_st_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pco_apb_rsp_type;

  typedef struct packed {
    logic       glob_en;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
  } pco_ctrl_type;

endpackage

/* logic/pco_wrap_det.sv */
// module: detects the all-ones to zero wrap of each event counter
`timescale 1ns/10ps
module pco_wrap_det #(
  parameter int unsigned NUM_CNT = 40
) (
  // counter activity
  input  wire logic [NUM_CNT-1:0]                 cnt_inc,
  input  wire logic [NUM_CNT*pco_pkg::CNT_W-1:0]  cnt_val,
  // wrap events
  output logic      [NUM_CNT-1:0]                 wrap
);

  // ************************************************************
  // wrap detection
  // ************************************************************
  // a counter wraps when it is stepped while holding all ones
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      wrap[i] = cnt_inc[i] & (&cnt_val[i*pco_pkg::CNT_W +: pco_pkg::CNT_W]);
    end
  end

endmodule

/* logic/pco_irq.sv */
// module: overflow flags, interrupt enables and overflow request behind an APB slave
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module pco_irq #(
  parameter int unsigned NUM_CNT = 40
) (
  // clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                rst_n,
  // apb slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [pco_pkg::ADDR_W-1:0]          paddr,
  input  wire logic [pco_pkg::DATA_W-1:0]          pwdata,
  output logic      [pco_pkg::DATA_W-1:0]          prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // event counters
  input  wire logic [NUM_CNT-1:0]                  cnt_inc,
  input  wire logic [NUM_CNT*pco_pkg::CNT_W-1:0]   cnt_val,
  output logic                                     cnt_glob_en,
  // interrupts
  output logic                                     ovf_irq,
  output logic                                     irq
);

  // ************************************************************
  // sizing
  // ************************************************************
  localparam int unsigned NUM_REGS = (NUM_CNT + 31) / 32;
  localparam int unsigned TAIL     = NUM_CNT % 32;
  localparam logic [31:0] RAZ_MASK = (TAIL == 0) ? 32'h0 :
                                     ~((32'h1 << TAIL) - 32'h1);

  typedef struct packed {
    pco_pkg::pco_apb_st_type  st;
    pco_pkg::pco_apb_rsp_type rsp;
    pco_pkg::pco_ctrl_type    ctl;
    logic [NUM_CNT-1:0]       ien;
    logic [NUM_CNT-1:0]       ovf;
    logic                     ovf_irq;
    logic                     irq;
  } pco_state_type;

  pco_state_type      s_r;
  pco_state_type      s_nxt;
  logic [NUM_CNT-1:0] wrap;

  // ************************************************************
  // helpers
  // ************************************************************
  // spread a written word over the counters of instance x
  function automatic logic [NUM_CNT-1:0] bank_bits(input logic [31:0] w,
                                                   input logic [2:0]  x);
    logic [NUM_CNT-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_CNT; i++) begin
      if (i / 32 == int'(x)) begin
        r[i] = w[i % 32];
      end
    end
    return r;
  endfunction

  // gather the counters of instance x into a word, absent ones read zero
  function automatic logic [31:0] bank_word(input logic [NUM_CNT-1:0] v,
                                            input logic [2:0]         x);
    logic [31:0] r;
    int          idx;
    r = '0;
    for (int j = 0; j < 32; j++) begin
      idx = int'(x) * 32 + j;
      if (idx < NUM_CNT) begin
        r[j] = v[idx];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // overflow detection
  // ************************************************************
  pco_wrap_det #(
    .NUM_CNT (NUM_CNT)
  ) u_wrap (
    .cnt_inc (cnt_inc),
    .cnt_val (cnt_val),
    .wrap    (wrap)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  logic               setup;
  logic               acc;
  logic               wr;
  logic [2:0]         view;
  logic [2:0]         inst;
  logic               bank_hit;
  logic               misc_hit;
  logic               any_hit;
  logic [NUM_CNT-1:0] wmask;
  logic [31:0]        ien_word;
  logic [31:0]        ovf_word;

  assign setup    = psel & ~penable & (s_r.st == pco_pkg::APB_IDLE);
  assign acc      = psel & penable & (s_r.st == pco_pkg::APB_ACCESS);
  assign wr       = acc & pwrite;
  assign view     = paddr[7:5];
  assign inst     = paddr[4:2];
  assign bank_hit = (paddr[11:8] == 4'h0) && (view <= pco_pkg::VIEW_OVSET)
                    && (int'(inst) < NUM_REGS) && (paddr[1:0] == 2'h0);
  assign misc_hit = (paddr == pco_pkg::CTRL_OFS) || (paddr == pco_pkg::STAT_OFS)
                    || (paddr == pco_pkg::MASK_OFS);
  assign any_hit  = bank_hit | misc_hit;
  assign wmask    = bank_bits(pwdata, inst);
  assign ien_word = bank_word(s_r.ien, inst);
  assign ovf_word = bank_word(s_r.ovf, inst);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [31:0] rd;
    s_nxt = s_r;
    rd    = 32'h0;

    // enables: one shared flag per counter behind both views
    if (wr && bank_hit && view == pco_pkg::VIEW_ENSET) begin
      s_nxt.ien = s_r.ien | wmask;
    end
    if (wr && bank_hit && view == pco_pkg::VIEW_ENCLR) begin
      s_nxt.ien = s_r.ien & ~wmask;
    end

    // overflow flags: software first, then hardware wrap so a wrap is never lost
    if (wr && bank_hit && view == pco_pkg::VIEW_OVCLR) begin
      s_nxt.ovf = s_r.ovf & ~wmask;
    end
    if (wr && bank_hit && view == pco_pkg::VIEW_OVSET) begin
      s_nxt.ovf = s_r.ovf | wmask;
    end
    s_nxt.ovf = s_nxt.ovf | wrap;

    // control and interrupt mask
    if (wr && paddr == pco_pkg::CTRL_OFS) begin
      s_nxt.ctl.glob_en = pwdata[pco_pkg::CTRL_GEN_BIT];
    end
    if (wr && paddr == pco_pkg::MASK_OFS) begin
      s_nxt.ctl.irq_mask = pwdata[pco_pkg::IRQ_SRC_W-1:0];
    end

    // sticky status: clear only what the read returned, new events win
    if (acc && !pwrite && paddr == pco_pkg::STAT_OFS) begin
      s_nxt.ctl.irq_stat = s_r.ctl.irq_stat & ~s_r.rsp.prdata[pco_pkg::IRQ_SRC_W-1:0];
    end
    s_nxt.ctl.irq_stat[pco_pkg::STAT_OVF_BIT] = s_nxt.ctl.irq_stat[pco_pkg::STAT_OVF_BIT]
                                                | (|wrap);
    s_nxt.ctl.irq_stat[pco_pkg::STAT_ERR_BIT] = s_nxt.ctl.irq_stat[pco_pkg::STAT_ERR_BIT]
                                                | (acc & ~any_hit);

    // read mux, sampled in the setup cycle
    if (bank_hit) begin
      unique case (view)
        pco_pkg::VIEW_ENCLR: rd = ien_word;
        pco_pkg::VIEW_ENSET: rd = ien_word;
        pco_pkg::VIEW_OVCLR: rd = ovf_word;
        pco_pkg::VIEW_OVSET: rd = ovf_word;
        default:             rd = 32'h0;
      endcase
    end else if (paddr == pco_pkg::CTRL_OFS) begin
      rd[pco_pkg::CTRL_GEN_BIT] = s_r.ctl.glob_en;
    end else if (paddr == pco_pkg::STAT_OFS) begin
      rd[pco_pkg::IRQ_SRC_W-1:0] = s_r.ctl.irq_stat;
    end else if (paddr == pco_pkg::MASK_OFS) begin
      rd[pco_pkg::IRQ_SRC_W-1:0] = s_r.ctl.irq_mask;
    end

    // apb: answer always in the first access cycle
    unique case (s_r.st)
      pco_pkg::APB_IDLE: begin
        if (setup) begin
          s_nxt.st          = pco_pkg::APB_ACCESS;
          s_nxt.rsp.pready  = 1'b1;
          s_nxt.rsp.pslverr = ~any_hit;
          s_nxt.rsp.prdata  = pwrite ? 32'h0 : rd;
        end
      end
      pco_pkg::APB_ACCESS: begin
        s_nxt.st          = pco_pkg::APB_IDLE;
        s_nxt.rsp.pready  = 1'b0;
        s_nxt.rsp.pslverr = 1'b0;
      end
      default: begin
        s_nxt.st  = pco_pkg::APB_IDLE;
        s_nxt.rsp = '0;
      end
    endcase

    // outputs from the next state so the ports sit straight on flops
    s_nxt.ovf_irq = s_nxt.ctl.glob_en & (|(s_nxt.ovf & s_nxt.ien));
    s_nxt.irq     = |(s_nxt.ctl.irq_stat & s_nxt.ctl.irq_mask);
  end

  // ************************************************************
  // state register
  // ************************************************************
  // flags have no defined reset value; zero is chosen so no stale request fires
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r    <= '0;
      s_r.st <= pco_pkg::APB_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata      = s_r.rsp.prdata;
  assign pready      = s_r.rsp.pready;
  assign pslverr     = s_r.rsp.pslverr;
  assign cnt_glob_en = s_r.ctl.glob_en;
  assign ovf_irq     = s_r.ovf_irq;
  assign irq         = s_r.irq;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic wr_enset;
  logic wr_enclr;
  logic wr_ovclr;
  logic rd_bank;

  assign wr_enset = wr && bank_hit && view == pco_pkg::VIEW_ENSET;
  assign wr_enclr = wr && bank_hit && view == pco_pkg::VIEW_ENCLR;
  assign wr_ovclr = wr && bank_hit && view == pco_pkg::VIEW_OVCLR;
  assign rd_bank  = setup && !pwrite && bank_hit;

  wrap_sets_flag_a: assert property (
    (wrap != '0) |=> ((s_r.ovf & $past(wrap)) == $past(wrap)))
    else $error("wrap did not set overflow flag");

  ovf_w1c_a: assert property (
    (wr_ovclr && wrap == '0) |=> ((s_r.ovf & $past(wmask)) == '0))
    else $error("overflow clear write left a flag set");

  en_set_a: assert property (
    wr_enset |=> ((s_r.ien & $past(wmask)) == $past(wmask)))
    else $error("enable set write did not enable");

  en_clr_a: assert property (
    wr_enclr |=> ((s_r.ien & $past(wmask)) == '0))
    else $error("enable clear write did not disable");

  zero_keeps_a: assert property (
    (wr_enset || wr_enclr) |=>
      ((s_r.ien & ~$past(wmask)) == ($past(s_r.ien) & ~$past(wmask))))
    else $error("zero bit changed an enable");

  en_read_a: assert property (
    (rd_bank && view <= pco_pkg::VIEW_ENSET) |=> (prdata == $past(ien_word)))
    else $error("enable view read mismatch");

  ovf_read_a: assert property (
    (rd_bank && view >= pco_pkg::VIEW_OVCLR) |=> (prdata == $past(ovf_word)))
    else $error("overflow view read mismatch");

  raz_bits_a: assert property (
    (rd_bank && int'(inst) == NUM_REGS - 1) |=> ((prdata & RAZ_MASK) == 32'h0))
    else $error("bits above implemented counters not zero");

  req_level_a: assert property (
    ovf_irq == (cnt_glob_en & (|(s_r.ovf & s_r.ien))))
    else $error("overflow request does not match flags and enables");

  glob_gate_a: assert property (
    !cnt_glob_en |-> !ovf_irq)
    else $error("overflow request while counters disabled");

  apb_answer_a: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb answer not one access cycle");

  irq_level_a: assert property (
    irq == (|(s_r.ctl.irq_stat & s_r.ctl.irq_mask)))
    else $error("interrupt output mismatch");

  req_rise_c:  cover property ($rose(ovf_irq));
  req_fall_c:  cover property ($fell(ovf_irq) ##0 cnt_glob_en);
  stat_rdclr_c: cover property (acc && !pwrite && paddr == pco_pkg::STAT_OFS && irq);
  slverr_c:    cover property (pready && pslverr);

endmodule

/* verification/pco_intc_model.sv */
// system interrupt controller model that takes the overflow request line
`timescale 1ns/10ps
module pco_intc_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // request lines from the block
  input  wire logic ovf_irq,
  input  wire logic irq,
  // own masking level, set by software of the system controller
  input  wire logic line_en,
  // pending state seen by the processor
  output logic      ovf_pend,
  output logic      blk_pend
);
  // ************************************************************
  // pending latch
  // ************************************************************
  // the controller adds its own enable on top of the block's enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_pend <= 1'h0;
      blk_pend <= 1'h0;
    end else begin
      ovf_pend <= ovf_irq & line_en;
      blk_pend <= irq & line_en;
    end
  end
endmodule

/* verification/tb.sv */
// self-checking testbench of the counter overflow interrupt block
`timescale 1ns/10ps
module tb;
  localparam int unsigned M = 40;
  logic              sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [M-1:0]      cnt_inc;
  logic [M*32-1:0]   cnt_val;
  logic              cnt_glob_en, ovf_irq, irq, line_en, ovf_pend, blk_pend, err;
  int                error_cnt, comparisons;

  pco_irq #(.NUM_CNT(M)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cnt_inc(cnt_inc), .cnt_val(cnt_val),
    .cnt_glob_en(cnt_glob_en), .ovf_irq(ovf_irq), .irq(irq));
  pco_intc_model intc (.sys_clk(sys_clk), .rst_n(rst_n), .ovf_irq(ovf_irq), .irq(irq),
    .line_en(line_en), .ovf_pend(ovf_pend), .blk_pend(blk_pend));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // the request stands until pready is seen high at a rising edge; only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1) begin
      @(posedge sys_clk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic lines(input logic eo, input logic ei);
    @(negedge sys_clk);
    chk("ovf_irq", {31'h0, eo}, {31'h0, ovf_irq});
    chk("irq", {31'h0, ei}, {31'h0, irq});
  endtask

  task automatic wrap(input int i, input logic [31:0] v);
    @(posedge sys_clk);
    cnt_inc[i]          <= 1'h1;
    cnt_val[i*32 +: 32] <= v;
    @(posedge sys_clk);
    cnt_inc <= '0;
  endtask

  // ************************************************************
  // clock, reset, watchdog
  // ************************************************************
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    rst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000;
    pwdata = 32'h0; cnt_inc = '0; cnt_val = '0; line_en = 1'h1;
    error_cnt = 0; comparisons = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    rchk("enable view", pco_pkg::ENCLR_BASE, 32'h0);
    rchk("flag view", pco_pkg::OVCLR_BASE, 32'h0);
    apb(1'h1, pco_pkg::ENSET_BASE, 32'hA5A50F0F);
    rchk("enable clear view", pco_pkg::ENCLR_BASE, 32'hA5A50F0F);
    apb(1'h1, pco_pkg::ENSET_BASE, 32'h0);
    rchk("enable set view", pco_pkg::ENSET_BASE, 32'hA5A50F0F);
    apb(1'h1, pco_pkg::ENCLR_BASE, 32'h00000F00);
    rchk("enable after clear", pco_pkg::ENSET_BASE, 32'hA5A5000F);
    apb(1'h1, pco_pkg::ENSET_BASE + 12'h004, 32'hFFFFFFFF);
    rchk("upper enables", pco_pkg::ENCLR_BASE + 12'h004, 32'h000000FF);
    apb(1'h0, pco_pkg::ENCLR_BASE + 12'h008, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'h1, pco_pkg::CTRL_OFS, 32'h1);
    @(negedge sys_clk);
    chk("global enable", 32'h1, {31'h0, cnt_glob_en});
    wrap(5, 32'hFFFFFFFE);
    rchk("no wrap", pco_pkg::OVCLR_BASE, 32'h0);
    wrap(3, 32'hFFFFFFFF);
    lines(1'h1, 1'h0);
    rchk("flag view", pco_pkg::OVCLR_BASE, 32'h00000008);
    wrap(39, 32'hFFFFFFFF);
    rchk("upper flags", pco_pkg::OVCLR_BASE + 12'h004, 32'h00000080);
    apb(1'h1, pco_pkg::OVCLR_BASE, 32'h00000008);
    rchk("flag cleared", pco_pkg::OVCLR_BASE, 32'h0);
    lines(1'h1, 1'h0);
    apb(1'h1, pco_pkg::OVCLR_BASE + 12'h004, 32'h00000080);
    lines(1'h0, 1'h0);
    apb(1'h1, pco_pkg::OVSET_BASE, 32'h00000010);
    rchk("flag set", pco_pkg::OVCLR_BASE, 32'h00000010);
    rchk("flag set view", pco_pkg::OVSET_BASE, 32'h00000010);
    lines(1'h0, 1'h0);
    apb(1'h1, pco_pkg::ENSET_BASE, 32'h00000010);
    lines(1'h1, 1'h0);
    @(negedge sys_clk);
    chk("controller pending", 32'h1, {31'h0, ovf_pend});
    apb(1'h1, pco_pkg::CTRL_OFS, 32'h0);
    lines(1'h0, 1'h0);
    apb(1'h1, pco_pkg::CTRL_OFS, 32'h1);
    lines(1'h1, 1'h0);
    apb(1'h1, pco_pkg::ENCLR_BASE, 32'h00000010);
    lines(1'h0, 1'h0);
    apb(1'h1, pco_pkg::MASK_OFS, 32'h1);
    lines(1'h0, 1'h1);
    rchk("status", pco_pkg::STAT_OFS, 32'h3);
    lines(1'h0, 1'h0);
    apb(1'h0, 12'h002, 32'h0);
    chk("unaligned error", 32'h1, {31'h0, err});
    lines(1'h0, 1'h0);
    apb(1'h1, pco_pkg::MASK_OFS, 32'h2);
    lines(1'h0, 1'h1);
    rchk("status", pco_pkg::STAT_OFS, 32'h2);
    lines(1'h0, 1'h0);
    end_sim();
  end
endmodule
